// ---- design/smr_defines.svh ----
// Offsets, field positions, reset values and timing counts of the stop-recovery block.
// Assumes the includer compiles it once per unit; the guard protects against repeats.
`ifndef SMR_DEFINES_SVH
`define SMR_DEFINES_SVH

`define SMR_ADDR_CTRL 8'h00
`define SMR_ADDR_RSTAT 8'h04
`define SMR_ADDR_IRQ_STATUS 8'h08
`define SMR_ADDR_IRQ_CLEAR 8'h0c
`define SMR_ADDR_IRQ_ENABLE 8'h10
`define SMR_ADDR_VECTOR 8'h14
`define SMR_ADDR_STATE 8'h18

`define SMR_CTRL_DOG_INT 0
`define SMR_CTRL_GLOBAL_IE 1
`define SMR_CTRL_TIMER_EN 2
`define SMR_CTRL_COMP_EN 3
`define SMR_CTRL_PIN_LSB 8
`define SMR_CTRL_RESET 32'h0000_0000
`define SMR_WAKE_IDLE 13'h0300

`define SMR_RST_STOP 0
`define SMR_RST_DOG 1
`define SMR_RST_EXT 2
`define SMR_RST_DEBUG 3

`define SMR_IRQ_WAKE_DONE 0
`define SMR_IRQ_SYS_RESET 1
`define SMR_IRQ_DOG_WAKE 2
`define SMR_IRQ_PIN_WAKE 3

`define SMR_CORE_IRQ_DOG 0
`define SMR_CORE_IRQ_TIMER 1
`define SMR_CORE_IRQ_COMP 2

`define SMR_VEC_HI_ADDR 16'h0002
`define SMR_VEC_LO_ADDR 16'h0003

`define SMR_CLK_MHZ 200
`define SMR_RECOVERY_NS 1000
`define SMR_RECOVERY_CYCLES ((`SMR_RECOVERY_NS * `SMR_CLK_MHZ + 999) / 1000)

`endif

// ---- design/smr_pkg.sv ----
// Types shared by the stop-recovery block and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package smr_pkg;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_STOP = 3'b001,
        ST_RECOVER = 3'b010,
        ST_FETCH_HI = 3'b011,
        ST_FETCH_LO = 3'b100,
        ST_LOAD = 3'b101,
        ST_DELIVER = 3'b110
    } smr_state_t;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'b000,
        CAUSE_DOG = 3'b001,
        CAUSE_TIMER = 3'b010,
        CAUSE_COMP = 3'b011,
        CAUSE_PIN = 3'b100,
        CAUSE_EXT = 3'b101,
        CAUSE_DEBUG = 3'b110
    } wake_cause_t;

    typedef struct packed {
        logic dogTimeout;
        logic timerIrq;
        logic compIrq;
        logic extReset_n;
        logic debugPin;
        logic [7:0] portPins;
    } wake_src_t;

endpackage

// ---- design/pin_sync.sv ----
// Three-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous; the output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 13,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Raw and cleaned levels
    input wire logic [WIDTH-1:0] rawIn,
    output logic [WIDTH-1:0] cleanOut
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    stage1[i] <= RESET_VAL[i];
                    stage2[i] <= RESET_VAL[i];
                    stage3[i] <= RESET_VAL[i];
                    cleanOut[i] <= RESET_VAL[i];
                end else begin
                    stage1[i] <= rawIn[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i]) begin
                        cleanOut[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- design/wake_detect.sv ----
// Detects any level change on enabled port pins while armed.
// Assumes clean, synchronised pin levels and a one-cycle arm pulse at stop entry.
`timescale 1ns/1ps
`default_nettype none
module wake_detect (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Control
    input wire logic arm,
    input wire logic disarm,
    input wire logic [7:0] pinEnable,
    input wire logic [7:0] pins,
    // Result
    output logic pinWake
);
    logic [7:0] refLevel;
    logic armed;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            refLevel <= 8'h00;
            armed <= 1'b0;
        end else if (arm) begin
            refLevel <= pins;
            armed <= 1'b1;
        end else if (disarm) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pinWake <= 1'b0;
        end else begin
            pinWake <= armed && !arm && !disarm && (((pins ^ refLevel) & pinEnable) != 8'h00);
        end
    end
endmodule
`default_nettype wire

// ---- design/stop_mode_recovery.sv ----
// Stop-mode recovery controller with an AHB-Lite register slave.
// Assumes a core that pulses a stop request, program memory with one-cycle read latency,
// and wake sources that arrive asynchronously on pins.
`include "smr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module stop_mode_recovery
    import smr_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Wake sources from pins
    input wire wake_src_t wakeRaw,
    // Processor core
    input wire logic coreStopReq,
    output logic coreRun,
    output logic sysResetReq,
    output logic pcLoad,
    output logic [15:0] pcValue,
    output logic [2:0] coreIrqReq,
    // Program memory
    output logic progRead,
    output logic [15:0] progAddr,
    input wire logic [7:0] progData,
    // Interrupt
    output logic irq
);
    localparam logic [7:0] RECOVERY_CYCLES = 8'(`SMR_RECOVERY_CYCLES);

    smr_state_t state;
    wake_cause_t cause;
    wake_src_t wakeClean;
    logic [31:0] ctrl;
    logic [3:0] resetStatus;
    logic [3:0] irqStatus;
    logic [3:0] irqEnable;
    logic [3:0] irqSet;
    logic [7:0] recoverCount;
    logic [7:0] vecHi;
    logic pinWake;
    logic stopEntry;
    logic wakeDisarm;
    logic addrValid;
    logic addrWrite;
    logic [7:0] addrLatch;
    logic readPending;
    logic wrCtrl;
    logic wrClear;
    logic wrEnable;
    logic dogIntMode;
    logic globalIe;
    wake_cause_t next_cause;

    function automatic logic [31:0] regRead(input logic [7:0] a);
        if (a == `SMR_ADDR_CTRL) begin
            regRead = ctrl;
        end else if (a == `SMR_ADDR_RSTAT) begin
            regRead = {28'h0000000, resetStatus};
        end else if (a == `SMR_ADDR_IRQ_STATUS) begin
            regRead = {28'h0000000, irqStatus};
        end else if (a == `SMR_ADDR_IRQ_ENABLE) begin
            regRead = {28'h0000000, irqEnable};
        end else if (a == `SMR_ADDR_VECTOR) begin
            regRead = {16'h0000, pcValue};
        end else if (a == `SMR_ADDR_STATE) begin
            regRead = {21'h000000, 5'(cause), 3'h0, 3'(state)};
        end else begin
            regRead = 32'h0000_0000;
        end
    endfunction

    // Pin inputs are synchronised; reset and debug pins idle high.
    pin_sync #(
        .WIDTH(13),
        .RESET_VAL(`SMR_WAKE_IDLE)
    ) u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .rawIn(wakeRaw),
        .cleanOut(wakeClean)
    );

    assign stopEntry = (state == ST_RUN) && coreStopReq;
    assign wakeDisarm = (state == ST_STOP) && (next_cause != CAUSE_NONE);
    assign dogIntMode = ctrl[`SMR_CTRL_DOG_INT];
    assign globalIe = ctrl[`SMR_CTRL_GLOBAL_IE];

    wake_detect u_pins (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .arm(stopEntry),
        .disarm(wakeDisarm),
        .pinEnable(ctrl[`SMR_CTRL_PIN_LSB +: 8]),
        .pins(wakeClean.portPins),
        .pinWake(pinWake)
    );

    // Wake source priority while stopped: system resets first.
    always_comb begin
        next_cause = CAUSE_NONE;
        if (!wakeClean.extReset_n) begin
            next_cause = CAUSE_EXT;
        end else if (!wakeClean.debugPin) begin
            next_cause = CAUSE_DEBUG;
        end else if (wakeClean.dogTimeout) begin
            next_cause = CAUSE_DOG;
        end else if (wakeClean.timerIrq && ctrl[`SMR_CTRL_TIMER_EN]) begin
            next_cause = CAUSE_TIMER;
        end else if (wakeClean.compIrq && ctrl[`SMR_CTRL_COMP_EN]) begin
            next_cause = CAUSE_COMP;
        end else if (pinWake) begin
            next_cause = CAUSE_PIN;
        end
    end

    // AHB-Lite address phase; reads take one wait state.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            addrValid <= 1'b0;
            addrWrite <= 1'b0;
            addrLatch <= 8'h00;
            readPending <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            readPending <= 1'b0;
            if (readPending) begin
                hrdata <= regRead(addrLatch);
                hreadyout <= 1'b1;
            end
            if (hready) begin
                addrValid <= hsel && htrans[1];
                addrWrite <= hwrite;
                addrLatch <= haddr[7:0];
                if (hsel && htrans[1] && !hwrite) begin
                    readPending <= 1'b1;
                    hreadyout <= 1'b0;
                end
            end
        end
    end

    assign wrCtrl = addrValid && addrWrite && (addrLatch == `SMR_ADDR_CTRL);
    assign wrClear = addrValid && addrWrite && (addrLatch == `SMR_ADDR_IRQ_CLEAR);
    assign wrEnable = addrValid && addrWrite && (addrLatch == `SMR_ADDR_IRQ_ENABLE);

    // Control and enable registers.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl <= `SMR_CTRL_RESET;
            irqEnable <= 4'h0;
        end else begin
            if (wrCtrl) begin
                ctrl <= {16'h0000, hwdata[15:8], 4'h0, hwdata[3:0]};
            end
            if (wrEnable) begin
                irqEnable <= hwdata[3:0];
            end
        end
    end

    // Recovery sequencer.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state <= ST_RUN;
            cause <= CAUSE_NONE;
            recoverCount <= 8'h00;
            coreRun <= 1'b1;
            sysResetReq <= 1'b0;
        end else begin
            sysResetReq <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (coreStopReq) begin
                        state <= ST_STOP;
                        coreRun <= 1'b0;
                    end
                end
                ST_STOP: begin
                    if (next_cause != CAUSE_NONE) begin
                        cause <= next_cause;
                        recoverCount <= 8'h00;
                        state <= ST_RECOVER;
                        sysResetReq <= (next_cause == CAUSE_EXT) || (next_cause == CAUSE_DEBUG);
                    end
                end
                ST_RECOVER: begin
                    if (recoverCount == RECOVERY_CYCLES - 8'h01) begin
                        state <= ST_FETCH_HI;
                    end else begin
                        recoverCount <= recoverCount + 8'h01;
                    end
                end
                ST_FETCH_HI: begin
                    state <= ST_FETCH_LO;
                end
                ST_FETCH_LO: begin
                    state <= ST_LOAD;
                end
                ST_LOAD: begin
                    coreRun <= 1'b1;
                    state <= ST_DELIVER;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // Reset vector fetch from program memory.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            progRead <= 1'b0;
            progAddr <= 16'h0000;
            vecHi <= 8'h00;
            pcLoad <= 1'b0;
            pcValue <= 16'h0000;
        end else begin
            pcLoad <= 1'b0;
            if (state == ST_RECOVER && recoverCount == RECOVERY_CYCLES - 8'h01) begin
                progRead <= 1'b1;
                progAddr <= `SMR_VEC_HI_ADDR;
            end else if (state == ST_FETCH_HI) begin
                progAddr <= `SMR_VEC_LO_ADDR;
            end else if (state == ST_FETCH_LO) begin
                progRead <= 1'b0;
                vecHi <= progData;
            end else if (state == ST_LOAD) begin
                pcValue <= {vecHi, progData};
                pcLoad <= 1'b1;
            end
        end
    end

    // Reset status flags; cleared on each stop entry.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            resetStatus <= 4'h0;
        end else if (stopEntry) begin
            resetStatus <= 4'h0;
        end else if (state == ST_STOP && next_cause != CAUSE_NONE) begin
            if (next_cause == CAUSE_EXT) begin
                resetStatus[`SMR_RST_EXT] <= 1'b1;
            end else if (next_cause == CAUSE_DEBUG) begin
                resetStatus[`SMR_RST_DEBUG] <= 1'b1;
            end else if (next_cause == CAUSE_DOG) begin
                resetStatus[`SMR_RST_DOG] <= 1'b1;
            end
        end else if (state == ST_LOAD && cause != CAUSE_EXT && cause != CAUSE_DEBUG) begin
            resetStatus[`SMR_RST_STOP] <= 1'b1;
        end
    end

    // Interrupt requests to the core, one cycle after the vector is loaded.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            coreIrqReq <= 3'b000;
        end else begin
            coreIrqReq <= 3'b000;
            if (state == ST_DELIVER && globalIe) begin
                coreIrqReq[`SMR_CORE_IRQ_DOG] <= (cause == CAUSE_DOG) && dogIntMode;
                coreIrqReq[`SMR_CORE_IRQ_TIMER] <= cause == CAUSE_TIMER;
                coreIrqReq[`SMR_CORE_IRQ_COMP] <= cause == CAUSE_COMP;
            end
        end
    end

    // Sticky event status; a set wins over a clear in the same cycle.
    always_comb begin
        irqSet = 4'h0;
        irqSet[`SMR_IRQ_WAKE_DONE] = pcLoad;
        irqSet[`SMR_IRQ_SYS_RESET] = sysResetReq;
        irqSet[`SMR_IRQ_DOG_WAKE] = (state == ST_STOP) && (next_cause == CAUSE_DOG);
        irqSet[`SMR_IRQ_PIN_WAKE] = (state == ST_STOP) && (next_cause == CAUSE_PIN);
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            irqStatus <= 4'h0;
            irq <= 1'b0;
        end else begin
            irqStatus <= (irqStatus & ~(wrClear ? hwdata[3:0] : 4'h0)) | irqSet;
            irq <= (((irqStatus & ~(wrClear ? hwdata[3:0] : 4'h0)) | irqSet) & irqEnable) != 4'h0;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    a_vector_hi_fetch: assert property (
        state == ST_FETCH_HI |-> progRead && progAddr == 16'h0002)
        else $error("High vector byte not fetched from 0002H.");
    a_vector_pc_load: assert property (
        state == ST_LOAD |=> pcLoad && pcValue == {vecHi, $past(progData)} && coreRun)
        else $error("Program counter not loaded from vector bytes.");
    a_stop_flag_set: assert property (
        state == ST_LOAD && cause inside {CAUSE_DOG, CAUSE_TIMER, CAUSE_COMP, CAUSE_PIN}
        |=> resetStatus[`SMR_RST_STOP])
        else $error("Stop flag missing after recovery.");
    a_dog_reset_mode: assert property (
        state == ST_DELIVER && cause == CAUSE_DOG && !dogIntMode |=> coreIrqReq == 3'b000)
        else $error("Watchdog reset mode raised an interrupt.");
    a_dog_wake_nosys: assert property (
        state == ST_STOP && next_cause == CAUSE_DOG |=> !sysResetReq ##0 state == ST_RECOVER)
        else $error("Watchdog wake caused a system reset.");
    a_dog_irq_order: assert property (
        coreIrqReq[`SMR_CORE_IRQ_DOG] |-> $past(pcLoad) && $past(state, 2) == ST_LOAD)
        else $error("Watchdog interrupt not after recovery.");
    a_dog_irq_given: assert property (
        state == ST_DELIVER && cause == CAUSE_DOG && dogIntMode && globalIe
        |=> coreIrqReq[`SMR_CORE_IRQ_DOG])
        else $error("Watchdog interrupt not delivered.");
    a_timer_irq_given: assert property (
        state == ST_DELIVER && cause == CAUSE_TIMER |=> coreIrqReq[`SMR_CORE_IRQ_TIMER] == globalIe)
        else $error("Timer interrupt delivery wrong.");
    a_comp_irq_given: assert property (
        state == ST_DELIVER && cause == CAUSE_COMP |=> coreIrqReq[`SMR_CORE_IRQ_COMP] == globalIe)
        else $error("Comparator interrupt delivery wrong.");
    a_pin_no_irq: assert property (
        state == ST_DELIVER && cause == CAUSE_PIN |=> coreIrqReq == 3'b000)
        else $error("Pin wake raised an interrupt.");
    a_ext_sys_reset: assert property (
        state == ST_STOP && !wakeClean.extReset_n |=> sysResetReq && resetStatus[`SMR_RST_EXT])
        else $error("External reset did not cause system reset.");
    a_debug_sys_reset: assert property (
        state == ST_STOP && wakeClean.extReset_n && !wakeClean.debugPin |=> sysResetReq)
        else $error("Debug pin low did not cause system reset.");
    a_dog_both_flags: assert property (
        state == ST_LOAD && cause == CAUSE_DOG |=> resetStatus[1:0] == 2'b11)
        else $error("Watchdog wake flags not both set.");
    a_timer_only_stop: assert property (
        state == ST_LOAD && cause == CAUSE_TIMER |=> resetStatus == 4'h1)
        else $error("Timer wake set flags other than stop.");

    c_dog_int_wake: cover property (coreIrqReq[`SMR_CORE_IRQ_DOG]);
    c_pin_wake: cover property (state == ST_DELIVER && cause == CAUSE_PIN);
    c_ext_reset: cover property (sysResetReq);
    c_timer_wake: cover property (coreIrqReq[`SMR_CORE_IRQ_TIMER]);
endmodule
`default_nettype wire

// ---- testbench/core_model.sv ----
// Core-side partner: stop request pulser and program memory holding the vector.
// Assumes the design reads memory one byte a cycle with one cycle of latency.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Bench control
    input wire logic [15:0] vector,
    input wire logic stopCmd,
    // Core side
    output logic coreStopReq,
    // Program memory
    input wire logic progRead,
    input wire logic [15:0] progAddr,
    output logic [7:0] progData
);
    logic stopSeen;
    always_ff @(posedge sys_clk) begin
        stopSeen <= stopCmd;
        coreStopReq <= reset_n && stopCmd && !stopSeen;
    end
    // Unread cycles show the inverse of the last byte.
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            progData <= 8'h5a;
        end else if (progRead && progAddr == 16'h0002) begin
            progData <= vector[15:8];
        end else if (progRead && progAddr == 16'h0003) begin
            progData <= vector[7:0];
        end else begin
            progData <= ~progData;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_stop_mode_recovery.sv ----
// Self-checking bench of the stop-mode recovery controller.
// Assumes the core model answers vector fetches and the bench masters AHB-Lite.
`include "smr_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_stop_mode_recovery
    import smr_pkg::*;
;
    localparam logic [12:0] IDLE = 13'h0300;
    logic sys_clk = 0, reset_n = 0, hsel = 0, hwrite = 0, stopCmd = 0, seenRst = 0;
    logic hready, hreadyout, hresp, coreStopReq, coreRun, sysResetReq, pcLoad, progRead, irq;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'b010;
    logic [2:0] coreIrqReq;
    logic [15:0] pcValue, progAddr, pcSeen;
    logic [15:0] vector = 0;
    logic [7:0] progData;
    wake_src_t wakeRaw = wake_src_t'(IDLE);
    logic [19:0] notes[$];
    int failures = 0, n_tests = 0, seed = 9019;
    assign hready = hreadyout;
    stop_mode_recovery u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .wakeRaw(wakeRaw),
        .coreStopReq(coreStopReq), .coreRun(coreRun), .sysResetReq(sysResetReq),
        .pcLoad(pcLoad), .pcValue(pcValue), .coreIrqReq(coreIrqReq), .progRead(progRead),
        .progAddr(progAddr), .progData(progData), .irq(irq));
    core_model u_core (.sys_clk(sys_clk), .reset_n(reset_n), .vector(vector),
        .stopCmd(stopCmd), .coreStopReq(coreStopReq), .progRead(progRead),
        .progAddr(progAddr), .progData(progData));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (exp !== got) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] r);
        int k;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            chk("bus address phase", 32'h1, 32'h0);
            test_done;
        end
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        r = hrdata;
        chk("bus response", 32'h0, {31'h0, hresp});
        if (k >= 50) begin
            chk("bus answer", 32'h1, 32'h0);
            test_done;
        end
    endtask
    task automatic wake(input logic [31:0] ctrl, input logic [12:0] flip,
        input logic [12:0] decoy, input logic [2:0] irqx, input logic rst,
        input logic [31:0] rstat);
        int k;
        logic [15:0] v;
        bus(1'b1, `SMR_ADDR_CTRL, ctrl, rd);
        v = 16'($random(seed));
        vector <= v;
        notes.push_back({rst, irqx, v});
        stopCmd <= 1'b1;
        repeat (4) @(posedge sys_clk);
        stopCmd <= 1'b0;
        wakeRaw <= wake_src_t'(IDLE ^ decoy);
        repeat (20) @(posedge sys_clk);
        chk("still stopped", 32'h0, {31'h0, coreRun});
        wakeRaw <= wake_src_t'(IDLE ^ decoy ^ flip);
        k = 0;
        do begin @(posedge sys_clk); k++; end while (coreRun !== 1'b1 && k < 400);
        if (k >= 400) begin
            chk("wake timeout", 32'h1, 32'h0);
            test_done;
        end
        chk("recovery time", 32'h1, {31'h0, k >= 200 && k <= 215});
        wakeRaw <= wake_src_t'(IDLE);
        repeat (10) @(posedge sys_clk);
        bus(1'b0, `SMR_ADDR_RSTAT, 32'h0, rd);
        chk("reset status", rstat, rd);
        bus(1'b0, `SMR_ADDR_VECTOR, 32'h0, rd);
        chk("vector", {16'h0, v}, rd);
        bus(1'b1, `SMR_ADDR_CTRL, ctrl, rd);
        $display("test wake %h done", flip);
    endtask
    // Watches the core side and compares each outcome with the oldest note.
    initial begin
        forever begin
            @(posedge sys_clk);
            #1;
            if (sysResetReq === 1'b1) seenRst = 1'b1;
            if (pcLoad === 1'b1) begin
                pcSeen = pcValue;
                @(posedge sys_clk);
                #1;
                if (notes.size() == 0) begin
                    chk("unexpected load", 32'h0, 32'h1);
                end else begin
                    chk("wake outcome", {12'h0, notes.pop_front()},
                        {12'h0, seenRst, coreIrqReq, pcSeen});
                end
                seenRst = 1'b0;
            end else if (coreIrqReq !== 3'b000) begin
                chk("early core irq", 32'h0, {29'h0, coreIrqReq});
            end
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        bus(1'b0, 8'h40, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        bus(1'b0, `SMR_ADDR_CTRL, 32'h0, rd);
        chk("ctrl reset", `SMR_CTRL_RESET, rd);
        wake(32'h2, 13'h1000, 13'h0, 3'b000, 1'b0, 32'h3);
        wake(32'h3, 13'h1000, 13'h0, 3'b001, 1'b0, 32'h3);
        wake(32'h6, 13'h0800, 13'h0, 3'b010, 1'b0, 32'h1);
        wake(32'h4, 13'h0800, 13'h0, 3'b000, 1'b0, 32'h1);
        wake(32'ha, 13'h0400, 13'h0, 3'b100, 1'b0, 32'h1);
        wake(32'h102, 13'h0001, 13'h0002, 3'b000, 1'b0, 32'h1);
        wake(32'h2, 13'h0200, 13'h0, 3'b000, 1'b1, 32'h4);
        wake(32'h2, 13'h0100, 13'h0, 3'b000, 1'b1, 32'h8);
        bus(1'b0, `SMR_ADDR_IRQ_STATUS, 32'h0, rd);
        chk("irq status", 32'hf, rd);
        bus(1'b1, `SMR_ADDR_IRQ_ENABLE, 32'h0, rd);
        repeat (3) @(posedge sys_clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, `SMR_ADDR_IRQ_ENABLE, 32'h8, rd);
        repeat (3) @(posedge sys_clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        bus(1'b1, `SMR_ADDR_IRQ_CLEAR, 32'h8, rd);
        repeat (3) @(posedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        bus(1'b0, `SMR_ADDR_IRQ_STATUS, 32'h0, rd);
        chk("irq status left", 32'h7, rd);
        bus(1'b0, `SMR_ADDR_IRQ_ENABLE, 32'h0, rd);
        chk("irq enable", 32'h8, rd);
        bus(1'b0, `SMR_ADDR_STATE, 32'h0, rd);
        chk("state reg", 32'h0000_0180, rd);
        $display("test interrupts done");
        test_done;
    end
endmodule
`default_nettype wire
